// >>> src/rx_global_pkg.sv
// Constants for the receiver global control register bank
package rx_global_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CNT_LOW    = 8'h00;
    localparam logic [7:0] IDX_CNT_HIGH   = 8'h01;
    localparam logic [7:0] IDX_SYNC_CTRL  = 8'h02;
    localparam logic [7:0] IDX_GLOBAL_CFG = 8'h22;
    localparam logic [7:0] IDX_FRAME_CFG  = 8'h24;
    localparam logic [7:0] IDX_DRIVE_CTRL = 8'h25;
    localparam logic [7:0] IDX_ONESHOT    = 8'h26;
    localparam logic [7:0] IDX_IRQ_MASK   = 8'h27;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h29;
    // Word index field inside the byte address
    localparam int ADDR_W   = 12;
    localparam int IDX_LSB  = 2;
    localparam int IDX_MSB  = 9;
    // Reset values
    localparam logic [15:0] DRIVE_RESET = 16'h87ff;
    localparam logic [15:0] ZERO16      = 16'h0000;
    // Frame configuration fields
    localparam int FR_DEL_LSB = 12;
    localparam int FR_DEL_MSB = 15;
    localparam int FR_LEN_LSB = 1;
    localparam int FR_LEN_MSB = 7;
    localparam int FR_POL_BIT = 0;
    // Drive control fields
    localparam int DRV_CLK_ENA = 15;
    localparam int DRV_GAIN_A  = 7;
    localparam int DRV_PAIR_0  = 3;
    localparam int DRV_PARCLK  = 1;
    localparam int DRV_IRQSYNC = 0;
    // One-shot trigger bit
    localparam int ONESHOT_BIT = 7;
    // Global config: interrupt clear bit
    localparam int INTR_CLR_BIT = 5;
    // Sync control fields
    localparam int SC_SEL_LSB = 8;
    localparam int SC_SEL_MSB = 10;
    localparam int SC_WID_LSB = 0;
    localparam int SC_WID_MSB = 7;
    // Status and mask field bases
    localparam int ST_CHAN_LSB  = 8;
    localparam int ST_INPUT_MSB = 7;
    localparam int ST_OVR_MSB   = 3;
    // Sync source codes
    typedef enum logic [2:0] {
        SRC_EXT_A   = 3'b000,
        SRC_EXT_B   = 3'b001,
        SRC_EXT_C   = 3'b010,
        SRC_EXT_D   = 3'b011,
        SRC_COUNTER = 3'b100,
        SRC_ONESHOT = 3'b101,
        SRC_ZERO    = 3'b110,
        SRC_ONE     = 3'b111
    } sync_src_t;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// >>> src/rx_global_ctrl.sv
// Receiver global control register bank with AXI4-Lite slave
//
// Function
// RULE_01 - Sync delay places sync versus first sample
// RULE_02 - Frame lasts field plus one clocks
// RULE_03 - Sync polarity bit selects low or high
// RULE_04 - Sample clock enable bit, resets to one
// RULE_05 - Disable bits active low, reset to one
// RULE_06 - Bits 10..7 drive gain groups d..a
// RULE_07 - Bits 3..6 drive channel pair outputs
// RULE_08 - Bit1 parallel clock, bit0 irq/sync
// RULE_09 - Trigger bit fires one sync pulse
// RULE_10 - Host rewrites zero then one to refire
// RULE_11 - Mask bits 15..8 gate channel meters
// RULE_12 - Mask bits 7..4 gate input meters
// RULE_13 - Mask bits 3..0 gate overflow ports
// RULE_14 - Status 15..8 flag channel meters 7..0
// RULE_15 - Status 7..4 flag input meters 0..3
// RULE_16 - Status 3..0 flag overflow pins a..d
// RULE_17 - Shared 32-bit counter, two halves
// RULE_18 - Software loads interval minus one
// RULE_19 - Counter advances every sample clock
// RULE_20 - Interrupt clear bit holds status cleared
// RULE_21 - Counter sync lasts 1 to 256 clocks
// RULE_22 - Codes 100/101 pick counter/one-shot
// RULE_23 - Status sticky, unmasked bits raise irq
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module rx_global_ctrl (
    input  wire logic        mclk,
    input  wire logic        srst,
    // AXI4-Lite slave
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Event sources
    input  wire logic [7:0]  chan_power_evt,
    input  wire logic [3:0]  input_power_evt,
    input  wire logic [3:0]  overflow_pin,
    input  wire logic [3:0]  ext_sync,
    // Block outputs
    output logic             sample_clk_en,
    output logic             par_sync_out,
    output logic             first_sample,
    output logic             block_sync,
    output logic             oneshot_pulse,
    output logic             irq,
    output logic [3:0]       gain_oe,
    output logic [3:0]       pair_oe,
    output logic             par_clk_oe,
    output logic             irq_sync_oe
);
    // Whole module state
    typedef struct packed {
        logic        aw_have;   // Write address held
        logic [7:0]  aw_idx;    // Held write index
        logic        aw_bad;    // Held address out of window
        logic        w_have;    // Write data held
        logic [15:0] w_data;    // Held write data
        logic [1:0]  w_strb;    // Held low byte lanes
        logic        awready;   // Address channel ready
        logic        wready;    // Data channel ready
        logic        bvalid;    // Write response pending
        logic [1:0]  bresp;     // Write response code
        logic        arready;   // Read address ready
        logic        rvalid;    // Read data pending
        logic [31:0] rdata;     // Read data word
        logic [1:0]  rresp;     // Read response code
        logic [15:0] cnt_low;   // Interval load low half
        logic [15:0] cnt_high;  // Interval load high half
        logic [15:0] sync_ctrl; // Source select and pulse width
        logic [15:0] gcfg;      // Global config
        logic [15:0] frame_cfg; // Frame configuration
        logic [15:0] drive;     // Output drive control
        logic [15:0] oneshot;   // One-shot trigger
        logic [15:0] mask;      // Interrupt mask
        logic [15:0] status;    // Sticky interrupt status
        logic        trig_prev; // Last trigger bit value
        logic [31:0] icount;    // Shared interval counter
        logic [8:0]  pw_left;   // Counter sync cycles left
        logic [6:0]  frame_cnt; // Position inside frame
        logic [15:0] hist;      // Frame start history
        logic        sync_act;  // Parallel sync active
        logic        par_sync;  // Parallel sync pin level
        logic        first;     // First channel sample flag
        logic        bsync;     // Selected block sync
        logic        pulse;     // One-shot pulse
        logic        irq;       // Interrupt level
        logic        clk_en;    // Sample clock enable
        logic [3:0]  gain_oe;   // Gain group enables a..d
        logic [3:0]  pair_oe;   // Pair enables 0/1..6/7
        logic        pclk_oe;   // Parallel clock enable
        logic        isync_oe;  // Irq and sync enable
    } state_t;

    state_t st_q;  // Registered state
    state_t st_d;  // Next state

    // Index of a byte address
    function automatic logic [7:0] word_idx(input logic [11:0] a);
        word_idx = a[rx_global_pkg::IDX_MSB:rx_global_pkg::IDX_LSB];
    endfunction

    // Address lies in the decoded window
    function automatic logic in_win(input logic [11:0] a);
        in_win = (a[rx_global_pkg::ADDR_W-1:rx_global_pkg::IDX_MSB+1]
                  == 2'b00) && (a[1:0] == 2'b00);
    endfunction

    // Index names an implemented register
    function automatic logic mapped(input logic [7:0] i);
        mapped = (i == rx_global_pkg::IDX_CNT_LOW)
              || (i == rx_global_pkg::IDX_CNT_HIGH)
              || (i == rx_global_pkg::IDX_SYNC_CTRL)
              || (i == rx_global_pkg::IDX_GLOBAL_CFG)
              || (i == rx_global_pkg::IDX_FRAME_CFG)
              || (i == rx_global_pkg::IDX_DRIVE_CTRL)
              || (i == rx_global_pkg::IDX_ONESHOT)
              || (i == rx_global_pkg::IDX_IRQ_MASK)
              || (i == rx_global_pkg::IDX_IRQ_STATUS);
    endfunction

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [1:0]  be);
        merge = {be[1] ? nw[15:8] : old[15:8],
                 be[0] ? nw[7:0]  : old[7:0]};
    endfunction

    // Next-state logic
    always_comb begin
        logic        wr_go;     // Write commits this cycle
        logic        wr_ok;     // Write hits a register
        logic [7:0]  ridx;      // Read index
        logic [15:0] rval;      // Read value
        logic [3:0]  dly;       // Sync delay field
        logic [6:0]  flen;      // Frame last position
        logic [31:0] load;      // Interval terminal value
        logic        wrap;      // Counter reached terminal
        logic        fstart;    // Frame starts now
        logic [15:0] hnext;     // History with current start
        logic        cnt_sync;  // Counter sync active
        logic [15:0] evt;       // Events in status layout
        logic        trig;      // Trigger bit now
        wr_go    = 1'b0;
        wr_ok    = 1'b0;
        ridx     = 8'h00;
        rval     = rx_global_pkg::ZERO16;
        dly      = 4'h0;
        flen     = 7'h00;
        load     = 32'h0000_0000;
        wrap     = 1'b0;
        fstart   = 1'b0;
        hnext    = rx_global_pkg::ZERO16;
        cnt_sync = 1'b0;
        evt      = rx_global_pkg::ZERO16;
        trig     = 1'b0;
        st_d     = st_q;

        // Capture write address and data in either order
        if (s_axi_awvalid && st_q.awready) begin
            st_d.aw_have = 1'b1;
            st_d.aw_idx  = word_idx(s_axi_awaddr);
            st_d.aw_bad  = !in_win(s_axi_awaddr);
        end
        if (s_axi_wvalid && st_q.wready) begin
            st_d.w_have = 1'b1;
            st_d.w_data = s_axi_wdata[15:0];
            st_d.w_strb = s_axi_wstrb[1:0];
        end
        // Response retires when taken
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end
        // Commit once both halves are held
        if (st_q.aw_have && st_q.w_have && !st_q.bvalid) begin
            wr_go       = 1'b1;
            wr_ok       = !st_q.aw_bad && mapped(st_q.aw_idx);
            st_d.aw_have = 1'b0;
            st_d.w_have  = 1'b0;
            st_d.bvalid  = 1'b1;
            st_d.bresp   = wr_ok ? rx_global_pkg::RESP_OKAY
                                 : rx_global_pkg::RESP_SLVERR;
        end
        st_d.awready = !st_d.aw_have;
        st_d.wready  = !st_d.w_have;

        // Register writes
        if (wr_go && wr_ok) begin
            unique case (st_q.aw_idx)
                rx_global_pkg::IDX_CNT_LOW: begin
                    st_d.cnt_low = merge(st_q.cnt_low, st_q.w_data,
                                         st_q.w_strb); // RULE_17
                end
                rx_global_pkg::IDX_CNT_HIGH: begin
                    st_d.cnt_high = merge(st_q.cnt_high, st_q.w_data,
                                          st_q.w_strb); // RULE_17
                end
                rx_global_pkg::IDX_SYNC_CTRL: begin
                    st_d.sync_ctrl = merge(st_q.sync_ctrl, st_q.w_data,
                                           st_q.w_strb);
                end
                rx_global_pkg::IDX_GLOBAL_CFG: begin
                    st_d.gcfg = merge(st_q.gcfg, st_q.w_data,
                                      st_q.w_strb);
                end
                rx_global_pkg::IDX_FRAME_CFG: begin
                    st_d.frame_cfg = merge(st_q.frame_cfg, st_q.w_data,
                                           st_q.w_strb);
                end
                rx_global_pkg::IDX_DRIVE_CTRL: begin
                    st_d.drive = merge(st_q.drive, st_q.w_data,
                                       st_q.w_strb);
                end
                rx_global_pkg::IDX_ONESHOT: begin
                    st_d.oneshot = merge(st_q.oneshot, st_q.w_data,
                                         st_q.w_strb);
                end
                rx_global_pkg::IDX_IRQ_MASK: begin
                    st_d.mask = merge(st_q.mask, st_q.w_data,
                                      st_q.w_strb);
                end
                default: begin
                    // Status is read only; writes are accepted
                end
            endcase
        end

        // Read channel: one read at a time
        if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_q.arready) begin
            ridx = word_idx(s_axi_araddr);
            unique case (ridx)
                rx_global_pkg::IDX_CNT_LOW:    rval = st_q.cnt_low;
                rx_global_pkg::IDX_CNT_HIGH:   rval = st_q.cnt_high;
                rx_global_pkg::IDX_SYNC_CTRL:  rval = st_q.sync_ctrl;
                rx_global_pkg::IDX_GLOBAL_CFG: rval = st_q.gcfg;
                rx_global_pkg::IDX_FRAME_CFG:  rval = st_q.frame_cfg;
                rx_global_pkg::IDX_DRIVE_CTRL: rval = st_q.drive;
                rx_global_pkg::IDX_ONESHOT:    rval = st_q.oneshot;
                rx_global_pkg::IDX_IRQ_MASK:   rval = st_q.mask;
                rx_global_pkg::IDX_IRQ_STATUS: rval = st_q.status;
                default:                       rval = rx_global_pkg::ZERO16;
            endcase
            st_d.rvalid = 1'b1;
            st_d.rdata  = {rx_global_pkg::ZERO16, rval};
            st_d.rresp  = (in_win(s_axi_araddr) && mapped(ridx))
                        ? rx_global_pkg::RESP_OKAY
                        : rx_global_pkg::RESP_SLVERR;
        end
        st_d.arready = !st_d.rvalid;

        // Sample clock enable from an active high bit, output enables from active low bits
        st_d.clk_en   = st_q.drive[rx_global_pkg::DRV_CLK_ENA]; // RULE_04
        st_d.gain_oe  = ~st_q.drive[rx_global_pkg::DRV_GAIN_A +: 4];
        // RULE_05 RULE_06
        st_d.pair_oe  = ~st_q.drive[rx_global_pkg::DRV_PAIR_0 +: 4];
        // RULE_07
        st_d.pclk_oe  = !st_q.drive[rx_global_pkg::DRV_PARCLK]; // RULE_08
        st_d.isync_oe = !st_q.drive[rx_global_pkg::DRV_IRQSYNC]; // RULE_08

        // One-shot fires on the zero-to-one change only
        trig           = st_q.oneshot[rx_global_pkg::ONESHOT_BIT];
        st_d.trig_prev = trig;
        st_d.pulse     = trig && !st_q.trig_prev; // RULE_09 RULE_10

        // Frame timing, frozen while the sample clock is off
        dly    = st_q.frame_cfg[rx_global_pkg::FR_DEL_MSB:
                                rx_global_pkg::FR_DEL_LSB];
        flen   = st_q.frame_cfg[rx_global_pkg::FR_LEN_MSB:
                                rx_global_pkg::FR_LEN_LSB];
        fstart = st_q.clk_en && (st_q.frame_cnt == 7'h00);
        hnext  = {st_q.hist[14:0], fstart};
        if (st_q.clk_en) begin
            st_d.frame_cnt = (st_q.frame_cnt >= flen) ? 7'h00
                           : st_q.frame_cnt + 7'h01; // RULE_02
            st_d.hist      = hnext;
            st_d.first     = hnext[1];    // RULE_01
            st_d.sync_act  = hnext[dly];  // RULE_01
        end
        st_d.par_sync = st_d.sync_act
                      ? st_q.frame_cfg[rx_global_pkg::FR_POL_BIT]
                      : !st_q.frame_cfg[rx_global_pkg::FR_POL_BIT];
        // RULE_03

        // Shared interval counter and its sync pulse
        load = {st_q.cnt_high, st_q.cnt_low};
        wrap = st_q.icount >= load;
        if (wr_go && wr_ok && (st_q.aw_idx == rx_global_pkg::IDX_CNT_LOW
            || st_q.aw_idx == rx_global_pkg::IDX_CNT_HIGH)) begin
            st_d.icount = 32'h0000_0000; // Restart on reload
        end else if (st_q.clk_en) begin
            st_d.icount = wrap ? 32'h0000_0000
                               : st_q.icount + 32'h0000_0001; // RULE_19
            if (wrap) begin
                st_d.pw_left = {1'b0, st_q.sync_ctrl[
                    rx_global_pkg::SC_WID_MSB:rx_global_pkg::SC_WID_LSB]}
                    + 9'h001; // RULE_21
            end else if (st_q.pw_left != 9'h000) begin
                st_d.pw_left = st_q.pw_left - 9'h001;
            end
        end
        cnt_sync = st_q.pw_left != 9'h000;

        // Block sync source selection
        unique case (rx_global_pkg::sync_src_t'(st_q.sync_ctrl[
                     rx_global_pkg::SC_SEL_MSB:rx_global_pkg::SC_SEL_LSB]))
            rx_global_pkg::SRC_EXT_A:   st_d.bsync = ext_sync[0];
            rx_global_pkg::SRC_EXT_B:   st_d.bsync = ext_sync[1];
            rx_global_pkg::SRC_EXT_C:   st_d.bsync = ext_sync[2];
            rx_global_pkg::SRC_EXT_D:   st_d.bsync = ext_sync[3];
            rx_global_pkg::SRC_COUNTER: st_d.bsync = cnt_sync; // RULE_22
            rx_global_pkg::SRC_ONESHOT: st_d.bsync = st_q.pulse; // RULE_22
            rx_global_pkg::SRC_ZERO:    st_d.bsync = 1'b0;
            rx_global_pkg::SRC_ONE:     st_d.bsync = 1'b1;
        endcase

        // Events mapped into the status layout
        for (int i = 0; i < 8; i++) begin
            evt[rx_global_pkg::ST_CHAN_LSB + i] = chan_power_evt[i];
            // RULE_14
        end
        for (int i = 0; i < 4; i++) begin
            evt[rx_global_pkg::ST_INPUT_MSB - i] = input_power_evt[i];
            // RULE_15
            evt[rx_global_pkg::ST_OVR_MSB - i] = overflow_pin[i];
            // RULE_16
        end
        // Sticky status; the clear bit holds everything cleared
        if (st_q.gcfg[rx_global_pkg::INTR_CLR_BIT]) begin
            st_d.status = rx_global_pkg::ZERO16; // RULE_20
        end else begin
            st_d.status = st_q.status | evt; // RULE_23
        end
        // Only unmasked set bits reach the interrupt
        st_d.irq = |(st_q.status & ~st_q.mask); // RULE_11 RULE_12 RULE_13
    end

    // State register
    always_ff @(posedge mclk) begin
        if (srst) begin
            st_q          <= '0;
            st_q.drive    <= rx_global_pkg::DRIVE_RESET; // RULE_04 RULE_05
            st_q.clk_en   <= 1'b1;
            st_q.awready  <= 1'b1;
            st_q.wready   <= 1'b1;
            st_q.arready  <= 1'b1;
            st_q.par_sync <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign s_axi_awready = st_q.awready;
    assign s_axi_wready  = st_q.wready;
    assign s_axi_bvalid  = st_q.bvalid;
    assign s_axi_bresp   = st_q.bresp;
    assign s_axi_arready = st_q.arready;
    assign s_axi_rvalid  = st_q.rvalid;
    assign s_axi_rdata   = st_q.rdata;
    assign s_axi_rresp   = st_q.rresp;
    assign sample_clk_en = st_q.clk_en;
    assign par_sync_out  = st_q.par_sync;
    assign first_sample  = st_q.first;
    assign block_sync    = st_q.bsync;
    assign oneshot_pulse = st_q.pulse;
    assign irq           = st_q.irq;
    assign gain_oe       = st_q.gain_oe;
    assign pair_oe       = st_q.pair_oe;
    assign par_clk_oe    = st_q.pclk_oe;
    assign irq_sync_oe   = st_q.isync_oe;

    logic wrap_chk;  // Counter terminal seen by checks
    assign wrap_chk = st_q.icount >= {st_q.cnt_high, st_q.cnt_low};

    // Checks on the block behaviour
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    oneshot_fire_a: assert property ( // RULE_09
        $rose(st_q.oneshot[rx_global_pkg::ONESHOT_BIT]) |=> st_q.pulse)
        else $error("one-shot pulse missing");
    oneshot_once_a: assert property ( // RULE_10
        st_q.pulse |=> !st_q.pulse)
        else $error("one-shot pulse repeated");
    irq_clear_a: assert property ( // RULE_20
        st_q.gcfg[rx_global_pkg::INTR_CLR_BIT] |=> st_q.status == 16'h0000)
        else $error("status not held cleared");
    irq_gate_a: assert property ( // RULE_23
        ##1 st_q.irq == $past(|(st_q.status & ~st_q.mask)))
        else $error("interrupt does not follow masked status");
    ovr_flag_a: assert property ( // RULE_16
        overflow_pin[0] && !st_q.gcfg[rx_global_pkg::INTR_CLR_BIT]
        |=> st_q.status[3])
        else $error("overflow a not flagged");
    chan_flag_a: assert property ( // RULE_14
        chan_power_evt[7] && !st_q.gcfg[rx_global_pkg::INTR_CLR_BIT]
        |=> st_q.status[15])
        else $error("channel meter 7 not flagged");
    count_step_a: assert property ( // RULE_19
        st_q.clk_en && !wrap_chk && !st_q.bvalid && !st_d.bvalid
        |=> st_q.icount == $past(st_q.icount) + 32'h0000_0001)
        else $error("interval counter did not advance");
    frame_wrap_a: assert property ( // RULE_02
        st_q.clk_en && st_q.frame_cnt == st_q.frame_cfg[
            rx_global_pkg::FR_LEN_MSB:rx_global_pkg::FR_LEN_LSB]
        |=> st_q.frame_cnt == 7'h00)
        else $error("frame did not wrap at its length");
    clk_stop_a: assert property ( // RULE_04
        !st_q.clk_en |=> $stable(st_q.frame_cnt))
        else $error("frame advanced with sample clock off");
    pair_oe_a: assert property ( // RULE_07
        ##1 pair_oe[0] == !$past(st_q.drive[rx_global_pkg::DRV_PAIR_0]))
        else $error("pair 0/1 enable wrong");
endmodule

// >>> bench/tb.sv
// Self-checking bench for the receiver global control register bank
`timescale 1ns/1ps
module tb;
    logic        mclk, srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic        sample_clk_en, par_sync_out, first_sample, block_sync;
    logic        oneshot_pulse, par_clk_oe, irq_sync_oe;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [7:0]  chan_power_evt;
    logic [3:0]  input_power_evt, overflow_pin, gain_oe, pair_oe;
    int          err_total, check_count, shots, hits, frm, lag, syn;
    logic        was;  // First-sample flag one cycle back
    // Output enables and clock enable packed for one compare
    wire  [10:0] pins = {sample_clk_en, gain_oe, pair_oe, par_clk_oe,
                         irq_sync_oe};
    rx_global_ctrl rx_global_ctrl_inst (.*, .s_axi_wstrb(4'h3),
                                        .ext_sync(4'h0));
    // 40 MHz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Count one-shot pulses
    always @(posedge mclk) begin
        if (oneshot_pulse === 1'b1) shots <= shots + 1;
    end
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // AXI4-Lite write of one 16-bit register
    task automatic wr(input logic [7:0] ix, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        s_axi_awaddr <= {2'b00, ix, 2'b00};
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 64);
        s_axi_bready <= 1'b0;
        rs = s_axi_bresp;
        if (n >= 64) begin
            err_total++;
            give_verdict();
        end
    endtask
    // AXI4-Lite read of one register
    task automatic rd(input logic [7:0] ix);
        int n;
        n = 0;
        @(posedge mclk);
        s_axi_araddr <= {2'b00, ix, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 64);
        s_axi_rready <= 1'b0;
        rv = s_axi_rdata;
        rs = s_axi_rresp;
        if (n >= 64) begin
            err_total++;
            give_verdict();
        end
    endtask
    // One-cycle event on the interrupt sources
    task automatic evt(input logic [7:0] c, input logic [3:0] p, o);
        @(posedge mclk);
        chan_power_evt <= c;
        input_power_evt <= p;
        overflow_pin <= o;
        @(posedge mclk);
        chan_power_evt <= 8'h00;
        input_power_evt <= 4'h0;
        overflow_pin <= 4'h0;
    endtask
    // Main sequence
    initial begin
        {srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h8;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, chan_power_evt, input_power_evt, overflow_pin} = '0;
        {err_total, check_count, shots, hits, frm, lag, syn} = '0;
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        rd(rx_global_pkg::IDX_DRIVE_CTRL);
        chk("drive reset", 32'h000087ff, rv);
        chk("pins reset", 32'h00000400, pins);
        chk("sync steady", 32'h00000000, par_sync_out);
        wr(rx_global_pkg::IDX_DRIVE_CTRL, 16'h0289);
        chk("wr okay", rx_global_pkg::RESP_OKAY, rs);
        repeat (2) @(posedge mclk);
        chk("pins mix", 32'h000002ba, pins);
        wr(rx_global_pkg::IDX_DRIVE_CTRL, 16'h8004);
        repeat (2) @(posedge mclk);
        chk("pins all on", 32'h000007ff, pins);
        rd(8'h30);
        chk("unmapped resp", rx_global_pkg::RESP_SLVERR, rs);
        chk("unmapped data", 32'h00000000, rv);
        wr(8'h30, 16'hffff);
        chk("unmapped wr", rx_global_pkg::RESP_SLVERR, rs);
        wr(rx_global_pkg::IDX_ONESHOT, 16'h0080);
        wr(rx_global_pkg::IDX_ONESHOT, 16'h0080);
        repeat (3) @(posedge mclk);
        chk("one shots", 32'h00000001, shots);
        wr(rx_global_pkg::IDX_ONESHOT, 16'h0000);
        wr(rx_global_pkg::IDX_ONESHOT, 16'h0080);
        repeat (3) @(posedge mclk);
        chk("re-fired", 32'h00000002, shots);
        evt(8'h01, 4'h1, 4'h1);
        rd(rx_global_pkg::IDX_IRQ_STATUS);
        chk("status low", 32'h00000188, rv);
        chk("irq set", 32'h00000001, irq);
        wr(rx_global_pkg::IDX_IRQ_MASK, 16'h0108);
        repeat (3) @(posedge mclk);
        chk("irq part", 32'h00000001, irq);
        wr(rx_global_pkg::IDX_IRQ_MASK, 16'h0188);
        repeat (3) @(posedge mclk);
        chk("irq masked", 32'h00000000, irq);
        rd(rx_global_pkg::IDX_IRQ_STATUS);
        chk("status kept", 32'h00000188, rv);
        wr(rx_global_pkg::IDX_GLOBAL_CFG, 16'h0020);
        evt(8'h80, 4'h8, 4'h8);
        rd(rx_global_pkg::IDX_IRQ_STATUS);
        chk("status clear", 32'h00000000, rv);
        wr(rx_global_pkg::IDX_GLOBAL_CFG, 16'h0000);
        evt(8'h80, 4'h8, 4'h8);
        rd(rx_global_pkg::IDX_IRQ_STATUS);
        chk("status high", 32'h00008011, rv);
        // Five-cycle frame, sync lags by one, active high
        wr(rx_global_pkg::IDX_FRAME_CFG, 16'h2009);
        // Counter source, pulse two cycles, interval ten
        wr(rx_global_pkg::IDX_SYNC_CTRL, 16'h0401);
        wr(rx_global_pkg::IDX_CNT_HIGH, 16'h0000);
        wr(rx_global_pkg::IDX_CNT_LOW, 16'h0009);
        rd(rx_global_pkg::IDX_CNT_LOW);
        chk("count low", 32'h00000009, rv);
        repeat (12) @(posedge mclk);
        was = first_sample;
        // Count over ten intervals and twenty frames
        repeat (100) begin
            @(posedge mclk);
            hits += (block_sync === 1'b1);
            frm += (first_sample === 1'b1);
            syn += (par_sync_out === 1'b1);
            lag += (par_sync_out === 1'b1 && was === 1'b1);
            was = first_sample;
        end
        chk("cnt syncs", 32'h00000014, hits);
        chk("frame starts", 32'h00000014, frm);
        chk("sync count", 32'h00000014, syn);
        chk("sync lag", 32'h00000014, lag);
        give_verdict();
    end
endmodule
